// ---- core/lsc_consts.svh ----
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define LSC_OFS_APC_FINE 8'h85
`define LSC_OFS_MOD_RANGE 8'h86
`define LSC_OFS_CTRL_ONE 8'h87
`define LSC_OFS_PWR_HI 8'h88
`define LSC_OFS_PWR_LO 8'h89
`define LSC_OFS_BIAS_HI 8'h8a
`define LSC_OFS_CTRL_TWO 8'h8b
`define LSC_OFS_INDEX 8'hb0
// ****************************************
// Reset values
// ****************************************
`define LSC_RST_ZERO 8'h00
`define LSC_RST_ONES 8'hff
// ****************************************
// Field positions and write masks
// ****************************************
`define LSC_APC_MASK 8'h03
`define LSC_RANGE_MASK 8'h07
`define LSC_CTRL_ONE_MASK 8'hf2
`define LSC_CTRL_TWO_MASK 8'h30
`define LSC_C1_DIR 1
`define LSC_C1_LO_MASK 4
`define LSC_C1_BIAS_MASK 5
`define LSC_C1_HI_MASK 6
`define LSC_C1_POL 7
`define LSC_C2_SRC 4
`define LSC_C2_SUPPLY 5
`define LSC_APC_MSB 1
`define LSC_RANGE_MSB 2
`define LSC_FLT_HI 2
`define LSC_FLT_BIAS 1
`define LSC_FLT_LO 0
// ****************************************
// Fault and gate reset values
// ****************************************
`define LSC_FLT_RST 3'h0
`define LSC_GATE_RST 1'b1
`endif

// ---- core/lsc_pkg.sv ----
package lsc_pkg;
  typedef logic [7:0] lsc_byte_t;
  typedef enum logic [1:0] {
    LSC_IDX_HOLD = 2'b00,
    LSC_IDX_AUTO = 2'b01,
    LSC_IDX_WRITE = 2'b10
  } lsc_idx_mode_t;
endpackage

// ---- core/lsc_regs.sv ----
// Summary of operation
// - Fine power reference is bits 1:0 of its register, bit 1 MSB, drives diode.
// - Modulation range is bits 2:0 of its register, bit 2 MSB, reset zero.
// - Control one bit 1 set makes monitor diode pin source, else sink.
// - Control one bit 4 masks power-low fault.
// - Control one bit 5 masks high-bias fault.
// - Control one bit 6 masks power-high fault.
// - Control one bit 7 picks disable gate asserted level, one means high.
// - Power above high threshold, reset all ones, raises power-high fault.
// - Power below low threshold, reset zero, raises power-low fault.
// - Bias above bias threshold, reset all ones, raises high-bias fault.
// - Control two bit 4 picks aux monitor two as index source, else temperature.
// - Control two bit 5 lets supply channel refresh each monitor pass.
// - Index pointer updates automatically and is writable under enable bits; reads need no enable.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
module lsc_regs (
  input wire logic clk, // 125 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic reg_wr, // Register write strobe from serial port
  input wire logic reg_rd, // Register read strobe from serial port
  input wire lsc_pkg::lsc_byte_t reg_addr, // Register address
  input wire lsc_pkg::lsc_byte_t reg_wdata, // Write data
  output lsc_pkg::lsc_byte_t reg_rdata, // Read data, registered
  input wire lsc_pkg::lsc_byte_t tx_power_meas, // Transmit power measurement
  input wire lsc_pkg::lsc_byte_t bias_meas, // Bias measurement
  input wire lsc_pkg::lsc_byte_t temp_meas, // Internal temperature index
  input wire lsc_pkg::lsc_byte_t aux_monitor_two, // Second auxiliary monitor
  input wire logic monitor_pass, // One pulse per monitor loop pass
  input wire lsc_pkg::lsc_byte_t supply_meas, // Supply voltage conversion
  input wire logic table_index_write_en, // Allows serial writes of the index
  input wire logic table_index_auto_en, // Allows automatic index update
  output lsc_pkg::lsc_byte_t supply_voltage_channel, // Supply channel result
  output lsc_pkg::lsc_byte_t table_index, // Lookup index pointer
  output logic [1:0] apc_fine_ref, // Fine power reference to diode loop
  output logic [2:0] modulation_set_output, // Modulation current range
  output logic diode_current_direction, // One sources, zero sinks
  output logic index_source_select, // One: aux monitor two
  output logic [2:0] quick_trip, // Unmasked faults: hi, bias, lo
  output logic laser_disable_gate // Laser disable, polarity programmable
);
  import lsc_pkg::*;

  // ****************************************
  // Configuration registers
  // ****************************************
  lsc_byte_t apc_fine_ff, nxt_apc_fine;
  lsc_byte_t range_ff, nxt_range;
  lsc_byte_t ctrl_one_ff, nxt_ctrl_one;
  lsc_byte_t pwr_hi_ff, nxt_pwr_hi;
  lsc_byte_t pwr_lo_ff, nxt_pwr_lo;
  lsc_byte_t bias_hi_ff, nxt_bias_hi;
  lsc_byte_t ctrl_two_ff, nxt_ctrl_two;
  lsc_byte_t rdata_ff, nxt_rdata;

  always_comb begin
    nxt_apc_fine = apc_fine_ff;
    nxt_range = range_ff;
    nxt_ctrl_one = ctrl_one_ff;
    nxt_pwr_hi = pwr_hi_ff;
    nxt_pwr_lo = pwr_lo_ff;
    nxt_bias_hi = bias_hi_ff;
    nxt_ctrl_two = ctrl_two_ff;
    // Reserved bits are cut on the way in, so reads need no mask of their own
    if (reg_wr) begin
      case (reg_addr)
        `LSC_OFS_APC_FINE: nxt_apc_fine = reg_wdata & `LSC_APC_MASK;
        `LSC_OFS_MOD_RANGE: nxt_range = reg_wdata & `LSC_RANGE_MASK;
        `LSC_OFS_CTRL_ONE: nxt_ctrl_one = reg_wdata & `LSC_CTRL_ONE_MASK;
        `LSC_OFS_PWR_HI: nxt_pwr_hi = reg_wdata;
        `LSC_OFS_PWR_LO: nxt_pwr_lo = reg_wdata;
        `LSC_OFS_BIAS_HI: nxt_bias_hi = reg_wdata;
        `LSC_OFS_CTRL_TWO: nxt_ctrl_two = reg_wdata & `LSC_CTRL_TWO_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apc_fine_ff <= `LSC_RST_ZERO;
      range_ff <= `LSC_RST_ZERO;
      ctrl_one_ff <= `LSC_RST_ZERO;
      pwr_hi_ff <= `LSC_RST_ONES;
      pwr_lo_ff <= `LSC_RST_ZERO;
      bias_hi_ff <= `LSC_RST_ONES;
      ctrl_two_ff <= `LSC_RST_ZERO;
    end else begin
      apc_fine_ff <= nxt_apc_fine;
      range_ff <= nxt_range;
      ctrl_one_ff <= nxt_ctrl_one;
      pwr_hi_ff <= nxt_pwr_hi;
      pwr_lo_ff <= nxt_pwr_lo;
      bias_hi_ff <= nxt_bias_hi;
      ctrl_two_ff <= nxt_ctrl_two;
    end
  end

  // A field written on one edge shows at the pins from the next
  chk_apc_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_APC_FINE)
      |=> apc_fine_ref == $past(reg_wdata[`LSC_APC_MSB:0]))
    else $error("fine reference write lost");
  chk_dir_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_CTRL_ONE)
      |=> diode_current_direction == $past(reg_wdata[`LSC_C1_DIR]))
    else $error("diode direction write lost");
  chk_src_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_CTRL_TWO)
      |=> index_source_select == $past(reg_wdata[`LSC_C2_SRC]))
    else $error("index source write lost");
  chk_hi_thresh_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_PWR_HI) |=> pwr_hi_ff == $past(reg_wdata))
    else $error("power-high threshold write lost");
  chk_lo_thresh_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_PWR_LO) |=> pwr_lo_ff == $past(reg_wdata))
    else $error("power-low threshold write lost");
  chk_bias_thresh_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_BIAS_HI) |=> bias_hi_ff == $past(reg_wdata))
    else $error("bias threshold write lost");
  chk_field_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    ((apc_fine_ff & ~`LSC_APC_MASK) == `LSC_RST_ZERO)
      && ((range_ff & ~`LSC_RANGE_MASK) == `LSC_RST_ZERO))
    else $error("reserved field bit set");

  // ****************************************
  // Lookup index pointer and supply channel
  // ****************************************
  lsc_byte_t index_ff, nxt_index;
  lsc_byte_t supply_ff, nxt_supply;
  lsc_idx_mode_t idx_mode;

  always_comb begin
    // A serial write wins over the automatic update in the same cycle
    if (reg_wr && reg_addr == `LSC_OFS_INDEX && table_index_write_en) begin
      idx_mode = LSC_IDX_WRITE;
    end else if (table_index_auto_en) begin
      idx_mode = LSC_IDX_AUTO;
    end else begin
      idx_mode = LSC_IDX_HOLD;
    end
    case (idx_mode)
      LSC_IDX_WRITE: nxt_index = reg_wdata;
      LSC_IDX_AUTO: nxt_index = ctrl_two_ff[`LSC_C2_SRC] ? aux_monitor_two : temp_meas;
      default: nxt_index = index_ff;
    endcase
    nxt_supply = supply_ff;
    if (monitor_pass && ctrl_two_ff[`LSC_C2_SUPPLY]) begin
      nxt_supply = supply_meas;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      index_ff <= `LSC_RST_ZERO;
      supply_ff <= `LSC_RST_ZERO;
    end else begin
      index_ff <= nxt_index;
      supply_ff <= nxt_supply;
    end
  end

  // Write priority matters: the automatic update would otherwise hide a serial write
  chk_index_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_INDEX && table_index_write_en)
      |=> table_index == $past(reg_wdata))
    else $error("index write lost");
  chk_index_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!table_index_auto_en && !(reg_wr && reg_addr == `LSC_OFS_INDEX && table_index_write_en))
      |=> $stable(table_index))
    else $error("index moved while idle");
  chk_index_temp: assert property (@(posedge clk) disable iff (sys_rst)
    (table_index_auto_en && !reg_wr && !ctrl_two_ff[`LSC_C2_SRC])
      |=> table_index == $past(temp_meas))
    else $error("index not from temperature");
  chk_supply_load: assert property (@(posedge clk) disable iff (sys_rst)
    (monitor_pass && ctrl_two_ff[`LSC_C2_SUPPLY])
      |=> supply_voltage_channel == $past(supply_meas))
    else $error("supply channel not refreshed");

  // ****************************************
  // Quick-trip faults and disable gate
  // ****************************************
  logic [2:0] fault_ff, nxt_fault;
  logic gate_ff, nxt_gate;

  always_comb begin
    nxt_fault[`LSC_FLT_HI] = (tx_power_meas > pwr_hi_ff) && !ctrl_one_ff[`LSC_C1_HI_MASK];
    nxt_fault[`LSC_FLT_BIAS] = (bias_meas > bias_hi_ff) && !ctrl_one_ff[`LSC_C1_BIAS_MASK];
    nxt_fault[`LSC_FLT_LO] = (tx_power_meas < pwr_lo_ff) && !ctrl_one_ff[`LSC_C1_LO_MASK];
    // Gate level is the asserted level when any fault is live, else its inverse
    nxt_gate = (|nxt_fault) ~^ ctrl_one_ff[`LSC_C1_POL];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_ff <= `LSC_FLT_RST;
      // Polarity resets to zero, so the deasserted level out of reset is high
      gate_ff <= `LSC_GATE_RST;
    end else begin
      fault_ff <= nxt_fault;
      gate_ff <= nxt_gate;
    end
  end

  // Strict compares: a reading equal to a threshold must leave the fault clear
  chk_hi_trip_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !(tx_power_meas > pwr_hi_ff) |=> !quick_trip[`LSC_FLT_HI])
    else $error("power-high fault without cause");
  chk_lo_trip_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !(tx_power_meas < pwr_lo_ff) |=> !quick_trip[`LSC_FLT_LO])
    else $error("power-low fault without cause");
  chk_bias_trip_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !(bias_meas > bias_hi_ff) |=> !quick_trip[`LSC_FLT_BIAS])
    else $error("bias fault without cause");

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    // The last read value stands until the next read; unmapped offsets give zero
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        `LSC_OFS_APC_FINE: nxt_rdata = apc_fine_ff;
        `LSC_OFS_MOD_RANGE: nxt_rdata = range_ff;
        `LSC_OFS_CTRL_ONE: nxt_rdata = ctrl_one_ff;
        `LSC_OFS_PWR_HI: nxt_rdata = pwr_hi_ff;
        `LSC_OFS_PWR_LO: nxt_rdata = pwr_lo_ff;
        `LSC_OFS_BIAS_HI: nxt_rdata = bias_hi_ff;
        `LSC_OFS_CTRL_TWO: nxt_rdata = ctrl_two_ff;
        `LSC_OFS_INDEX: nxt_rdata = index_ff;
        default: nxt_rdata = `LSC_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= `LSC_RST_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  chk_read_index: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `LSC_OFS_INDEX)
      |=> reg_rdata == $past(table_index))
    else $error("index read wrong");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr != `LSC_OFS_INDEX
      && (reg_addr < `LSC_OFS_APC_FINE || reg_addr > `LSC_OFS_CTRL_TWO))
      |=> reg_rdata == `LSC_RST_ZERO)
    else $error("unmapped read not zero");

  assign reg_rdata = rdata_ff;
  assign table_index = index_ff;
  assign supply_voltage_channel = supply_ff;
  assign apc_fine_ref = apc_fine_ff[`LSC_APC_MSB:0];
  assign modulation_set_output = range_ff[`LSC_RANGE_MSB:0];
  assign diode_current_direction = ctrl_one_ff[`LSC_C1_DIR];
  assign index_source_select = ctrl_two_ff[`LSC_C2_SRC];
  assign quick_trip = fault_ff;
  assign laser_disable_gate = gate_ff;

  // ****************************************
  // Checks
  // ****************************************
  chk_hi_fault_mask: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_one_ff[`LSC_C1_HI_MASK] |=> !quick_trip[2])
    else $error("masked power-high fault raised");
  chk_bias_fault_mask: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_one_ff[`LSC_C1_BIAS_MASK] |=> !quick_trip[1])
    else $error("masked bias fault raised");
  chk_lo_fault_mask: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_one_ff[`LSC_C1_LO_MASK] |=> !quick_trip[0])
    else $error("masked power-low fault raised");
  chk_hi_trip_cause: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_power_meas > pwr_hi_ff && !ctrl_one_ff[`LSC_C1_HI_MASK]) |=> quick_trip[2])
    else $error("power-high fault missed");
  chk_lo_trip_cause: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_power_meas < pwr_lo_ff && !ctrl_one_ff[`LSC_C1_LO_MASK]) |=> quick_trip[0])
    else $error("power-low fault missed");
  chk_bias_trip_cause: assert property (@(posedge clk) disable iff (sys_rst)
    (bias_meas > bias_hi_ff && !ctrl_one_ff[`LSC_C1_BIAS_MASK]) |=> quick_trip[1])
    else $error("bias fault missed");
  chk_gate_level: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 laser_disable_gate == ((|quick_trip) ~^ $past(ctrl_one_ff[`LSC_C1_POL])))
    else $error("disable gate level wrong");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_one_ff[0] == 1'b0) && (ctrl_two_ff[3:0] == 4'h0))
    else $error("reserved control bit set");
  chk_range_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `LSC_OFS_MOD_RANGE) |=> modulation_set_output == $past(reg_wdata[2:0]))
    else $error("range write lost");
  chk_supply_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_two_ff[`LSC_C2_SUPPLY] |=> $stable(supply_voltage_channel))
    else $error("supply channel updated while disabled");
  chk_index_source: assert property (@(posedge clk) disable iff (sys_rst)
    (table_index_auto_en && !reg_wr && ctrl_two_ff[`LSC_C2_SRC])
      |=> table_index == $past(aux_monitor_two))
    else $error("index not from aux monitor");
endmodule
`default_nettype wire

// ---- verification/lsc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Serial-port side register master
// ****
module lsc_host_model (
  input wire logic clk, // Device clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output lsc_pkg::lsc_byte_t reg_addr, // Register address
  output lsc_pkg::lsc_byte_t reg_wdata, // Write data
  input wire lsc_pkg::lsc_byte_t reg_rdata // Read data
);
  import lsc_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Idle bus shows the inverse of the last request, so a stale value never looks live
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input lsc_byte_t a, input lsc_byte_t d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    release_bus();
  endtask
  task automatic rd(input lsc_byte_t a, output lsc_byte_t d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    release_bus();
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lsc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, monitor_pass = 1'b0;
  logic table_index_write_en = 1'b0, table_index_auto_en = 1'b0;
  lsc_byte_t reg_addr, reg_wdata, reg_rdata, supply_voltage_channel, table_index;
  lsc_byte_t tx_power_meas = 8'h60, bias_meas = 8'h3d, temp_meas = 8'h24;
  lsc_byte_t aux_monitor_two = 8'h42, supply_meas = 8'h77;
  logic [1:0] apc_fine_ref;
  logic [2:0] modulation_set_output, quick_trip;
  logic diode_current_direction, index_source_select, laser_disable_gate;
  int failures = 0;
  int cmp_count = 0;
  // ****
  // Rows: address, reset value, write data, readback
  // ****
  localparam logic [31:0] ROWS [8] = '{32'h8500_ff03, 32'h8600_ff07, 32'h8700_fff2,
    32'h88ff_5a5a, 32'h8900_a5a5, 32'h8aff_3c3c, 32'h8b00_ff30, 32'hc000_ff00};
  always #4 clk = ~clk;
  lsc_host_model u_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  lsc_regs DUT (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .tx_power_meas, .bias_meas, .temp_meas, .aux_monitor_two, .monitor_pass, .supply_meas,
    .table_index_write_en, .table_index_auto_en, .supply_voltage_channel, .table_index,
    .apc_fine_ref, .modulation_set_output, .diode_current_direction, .index_source_select,
    .quick_trip, .laser_disable_gate);
  task automatic chk(input lsc_byte_t seen, input lsc_byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input lsc_byte_t a, input lsc_byte_t exp);
    lsc_byte_t d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  task automatic pulse();
    @(negedge clk);
    monitor_pass = 1'b1;
    @(negedge clk);
    monitor_pass = 1'b0;
    settle();
  endtask
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(8 * 3000);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    foreach (ROWS[i]) begin
      rdchk(ROWS[i][31:24], ROWS[i][23:16]);
      u_host.wr(ROWS[i][31:24], ROWS[i][15:8]);
      rdchk(ROWS[i][31:24], ROWS[i][7:0]);
    end
    settle();
    chk({6'h00, apc_fine_ref}, 8'h03);
    chk({5'h00, modulation_set_output}, 8'h07);
    chk({7'h00, diode_current_direction}, 8'h01);
    chk({5'h00, quick_trip}, 8'h00);
    chk({7'h00, laser_disable_gate}, 8'h00);
    u_host.wr(8'h87, 8'h80);
    settle();
    chk({5'h00, quick_trip}, 8'h07);
    chk({7'h00, laser_disable_gate}, 8'h01);
    chk({7'h00, diode_current_direction}, 8'h00);
    for (int k = 4; k < 7; k++) begin
      u_host.wr(8'h87, 8'h80 | (8'h01 << k));
      settle();
      chk({5'h00, quick_trip}, 8'h07 & ~(8'h01 << (k - 4)));
    end
    // Equal to a threshold must not trip
    tx_power_meas = 8'h5a;
    bias_meas = 8'h3c;
    u_host.wr(8'h87, 8'h80);
    settle();
    chk({5'h00, quick_trip}, 8'h01);
    u_host.wr(8'h87, 8'h10);
    settle();
    chk({7'h00, laser_disable_gate}, 8'h01);
    u_host.wr(8'h87, 8'h00);
    settle();
    chk({7'h00, laser_disable_gate}, 8'h00);
    table_index_auto_en = 1'b1;
    settle();
    chk({7'h00, index_source_select}, 8'h01);
    chk(table_index, 8'h42);
    u_host.wr(8'h8b, 8'h20);
    settle();
    chk(table_index, 8'h24);
    chk({7'h00, index_source_select}, 8'h00);
    pulse();
    chk(supply_voltage_channel, 8'h77);
    u_host.wr(8'h8b, 8'h00);
    supply_meas = 8'h11;
    pulse();
    chk(supply_voltage_channel, 8'h77);
    table_index_auto_en = 1'b0;
    table_index_write_en = 1'b1;
    u_host.wr(8'hb0, 8'h99);
    rdchk(8'hb0, 8'h99);
    table_index_write_en = 1'b0;
    u_host.wr(8'hb0, 8'h55);
    rdchk(8'hb0, 8'h99);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    settle();
    chk({7'h00, laser_disable_gate}, 8'h01);
    chk({5'h00, quick_trip}, 8'h00);
    chk({6'h00, apc_fine_ref}, 8'h00);
    rdchk(8'h88, 8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
